// *** logic/cvrc_pkg.sv ***
/*
 * constants shared by the converter run-control block: register map,
 * field positions, reset values, command codes, timer length, states.
 * assumes a 250 MHz pclk and a 32-bit apb register bus.
 */
package cvrc_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;

    // ------------------------------------------------------------------
    // command word fields and codes (code = top three command bits)
    // ------------------------------------------------------------------
    localparam int CMD_LSB = 5;
    localparam int DLO_LSB = 8;
    localparam int DHI_LSB = 16;
    localparam int CODE_LSB = 3;
    localparam int FLAG_POS = 2;
    localparam logic [2:0] CMD_ON = 3'h0;
    localparam logic [2:0] CMD_SETUP = 3'h1;
    localparam logic [2:0] CMD_READ = 3'h2;
    localparam logic [2:0] CMD_OFF = 3'h3;

    // ------------------------------------------------------------------
    // status fields, interrupt bits, reset values
    // ------------------------------------------------------------------
    localparam int ST_PINS_LSB = 6;
    localparam int ST_SEQ_LSB = 10;
    localparam int IRQ_SHUT = 0;
    localparam int IRQ_RUN = 1;
    localparam int IRQ_PGDONE = 2;
    localparam int IRQ_REFUSE = 3;
    localparam int IRQ_W = 4;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
    localparam logic [4:0] CODE_RESET = 5'h1F;

    // ------------------------------------------------------------------
    // power-ok low pulse: 50 us at 250 MHz
    // ------------------------------------------------------------------
    localparam int TMR_W = 16;
    localparam int unsigned PG_PULSE_NS = 50000;
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned PG_CYCLES_INT = PG_PULSE_NS * CLK_MHZ / 1000;
    localparam logic [TMR_W-1:0] PG_PULSE_CYCLES = TMR_W'(PG_CYCLES_INT);

    // on/off pair tracker
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_ON1 = 2'b01,
        SEQ_OFF1 = 2'b10
    } cvrc_seq_t;

endpackage

// *** logic/cvrc_pulse_timer.sv ***
/*
 * retriggerable down-counter that holds a pulse for a fixed cycle count.
 * assumes the trigger is a one-cycle pulse from logic on the same clock.
 */
module cvrc_pulse_timer #(
    parameter logic [cvrc_pkg::TMR_W-1:0] CYCLES = cvrc_pkg::PG_PULSE_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic trigger,
    // state
    output logic active,
    output logic done,
    output logic [cvrc_pkg::TMR_W-1:0] remaining
);
    import cvrc_pkg::*;

    // ------------------------------------------------------------------
    // count
    // ------------------------------------------------------------------
    logic [TMR_W-1:0] next_remaining;

    // a trigger mid-pulse reloads, so the pulse runs its full length again
    assign next_remaining = trigger ? CYCLES :
                            (remaining != '0) ? remaining - 1'b1 : remaining;
    assign active = remaining != '0;
    assign done = (remaining == {{(TMR_W-1){1'b0}}, 1'b1}) && !trigger;

    // counter register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remaining <= '0;
        end else begin
            remaining <= next_remaining;
        end
    end

endmodule

// *** logic/cvrc_run_control.sv ***
/*
 * converter run control: on/off pair tracker, divider code registers,
 * shutdown flag, open-drain run and power-ok pins, apb register slave.
 * assumes pins are asynchronous to pclk; open-drain pins are resolved
 * outside from the _oe outputs (the _out outputs are always low).
 */
// Implementation choices: the register addresses and the APB slave port.
// Function
// - select high picks register one, low zero
// - shutdown flag is nand of run, on
// - flag high drives all run pins low
// - flag low releases run pins to float
// - flag falling starts 50 us power-ok low
// - select change while running restarts pulse
// - reset leaves command tracker idle
// - reset loads both divider codes all ones
// - reset forces the shutdown flag high
// - reduced-pin variant treats run as high
// - two ons set state once codes were set up, two offs clear
// - status bit sits below divider code
// - setup refused while run and on high
module cvrc_run_control #(
    parameter logic [cvrc_pkg::TMR_W-1:0] PG_PULSE_CYCLES = cvrc_pkg::PG_PULSE_CYCLES,
    parameter logic REDUCED_PINS = 1'b0
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // control pins
    input wire logic global_run_input,
    input wire logic select_in,
    // open-drain converter run pins
    input wire logic run_cpu_in,
    output logic run_cpu_out,
    output logic run_cpu_oe,
    input wire logic run_io_in,
    output logic run_io_out,
    output logic run_io_oe,
    input wire logic run_clk_in,
    output logic run_clk_out,
    output logic run_clk_oe,
    // open-drain power-ok pin
    input wire logic power_ok_in,
    output logic power_ok_out,
    output logic power_ok_oe,
    // divider and interrupt
    output logic [4:0] divider_code,
    output logic irq
);
    import cvrc_pkg::*;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic run_meta, run_s, sel_meta, sel_s, sel_prev, flag_prev;
    logic [3:0] pin_meta, pin_s;
    logic run_eff, converters_off_flag, bus_on_state, armed, locked;
    cvrc_seq_t seq, next_seq;
    logic next_bus_on, next_armed;
    logic [4:0] reg0, reg1, next_reg0, next_reg1, next_code;
    logic sel_toggle, flag_fell, flag_rose, pulse_trig;
    logic pulse_active, pulse_done, next_pok_oe;
    logic [TMR_W-1:0] pulse_left;
    logic [IRQ_W-1:0] irq_stat, irq_mask, irq_ev, irq_clr;
    logic setup_ok, setup_refused;
    logic [31:0] rd_mux, status_word;

    // readback byte: code on top, status below it, two zero bits last
    function automatic logic [7:0] rb_byte(input logic [4:0] code,
                                           input logic flag);
        rb_byte = {code, flag, 2'b00};
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    // two flops each; only the second stage is looked at anywhere
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_meta <= 1'b0;
            run_s <= 1'b0;
            sel_meta <= 1'b0;
            sel_s <= 1'b0;
            pin_meta <= 4'h0;
            pin_s <= 4'h0;
        end else begin
            run_meta <= global_run_input;
            run_s <= run_meta;
            sel_meta <= select_in;
            sel_s <= sel_meta;
            pin_meta <= {power_ok_in, run_clk_in, run_io_in, run_cpu_in};
            pin_s <= pin_meta;
        end
    end

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    wire setup_ph = psel && !penable;
    wire access = psel && penable;
    wire hit_cmd = paddr == ADDR_CMD;
    wire hit_st = paddr == ADDR_STATUS;
    wire hit_is = paddr == ADDR_IRQ_STAT;
    wire hit_im = paddr == ADDR_IRQ_MASK;
    wire mapped = hit_cmd || hit_st || hit_is || hit_im;
    wire wr = access && pwrite && mapped;
    wire cmd_wr = wr && hit_cmd;
    wire rb_rd = access && !pwrite && hit_cmd;
    wire [2:0] cmd_code = pwdata[CMD_LSB +: 3];

    // zero-wait slave; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // ------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------
    wire is_on = cmd_wr && cmd_code == CMD_ON;
    wire is_off = cmd_wr && cmd_code == CMD_OFF;
    wire is_setup = cmd_wr && cmd_code == CMD_SETUP;
    // a read-back access is a protocol too, so it breaks a pending pair
    wire is_other = is_setup || rb_rd || (cmd_wr && cmd_code == CMD_READ);

    // ------------------------------------------------------------------
    // on/off pair tracker
    // ------------------------------------------------------------------
    // on commands count only once the codes were set up once
    always_comb begin
        next_seq = seq;
        next_bus_on = bus_on_state;
        if (is_on && armed) begin
            if (seq == SEQ_ON1) begin
                next_bus_on = 1'b1;
                next_seq = SEQ_IDLE;
            end else begin
                next_seq = SEQ_ON1;
            end
        end else if (is_off) begin
            if (seq == SEQ_OFF1) begin
                next_bus_on = 1'b0;
                next_seq = SEQ_IDLE;
            end else begin
                next_seq = SEQ_OFF1;
            end
        end else if (is_other || is_on) begin
            next_seq = SEQ_IDLE;
        end
    end

    // tracker state; reset parks it idle with the converters off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq <= SEQ_IDLE;
            bus_on_state <= 1'b0;
        end else begin
            seq <= next_seq;
            bus_on_state <= next_bus_on;
        end
    end

    // ------------------------------------------------------------------
    // divider code registers
    // ------------------------------------------------------------------
    assign locked = run_eff && bus_on_state;
    assign setup_ok = is_setup && !locked;
    assign setup_refused = is_setup && locked;
    assign next_reg0 = setup_ok ? pwdata[DLO_LSB + CODE_LSB +: 5] : reg0;
    assign next_reg1 = setup_ok ? pwdata[DHI_LSB + CODE_LSB +: 5] : reg1;
    assign next_armed = armed || setup_ok;
    assign next_code = sel_s ? reg1 : reg0;

    // registers and the code on the pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reg0 <= CODE_RESET;
            reg1 <= CODE_RESET;
            armed <= 1'b0;
            divider_code <= CODE_RESET;
        end else begin
            reg0 <= next_reg0;
            reg1 <= next_reg1;
            armed <= next_armed;
            divider_code <= next_code;
        end
    end

    // ------------------------------------------------------------------
    // shutdown flag and pulse triggers
    // ------------------------------------------------------------------
    assign run_eff = REDUCED_PINS ? 1'b1 : run_s;
    assign converters_off_flag = !(run_eff && bus_on_state);
    assign sel_toggle = sel_s ^ sel_prev;
    assign flag_fell = flag_prev && !converters_off_flag;
    assign flag_rose = !flag_prev && converters_off_flag;
    // select moves while shut down are not worth a pulse
    assign pulse_trig = flag_fell || (sel_toggle && !converters_off_flag);

    // previous samples for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_prev <= 1'b0;
            flag_prev <= 1'b1;
        end else begin
            sel_prev <= sel_s;
            flag_prev <= converters_off_flag;
        end
    end

    // power-ok low pulse timer
    cvrc_pulse_timer #(
        .CYCLES(PG_PULSE_CYCLES)
    ) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .trigger(pulse_trig),
        .active(pulse_active),
        .done(pulse_done),
        .remaining(pulse_left)
    );

    // ------------------------------------------------------------------
    // open-drain pins
    // ------------------------------------------------------------------
    // trigger term covers the cycle before the timer shows active
    assign next_pok_oe = converters_off_flag || pulse_active || pulse_trig;
    assign run_cpu_out = 1'b0;
    assign run_io_out = 1'b0;
    assign run_clk_out = 1'b0;
    assign power_ok_out = 1'b0;

    // drive low while shut down or, for power-ok, during the pulse; float otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_cpu_oe <= 1'b1;
            run_io_oe <= 1'b1;
            run_clk_oe <= 1'b1;
            power_ok_oe <= 1'b1;
        end else begin
            run_cpu_oe <= converters_off_flag;
            run_io_oe <= converters_off_flag;
            run_clk_oe <= converters_off_flag;
            power_ok_oe <= next_pok_oe;
        end
    end

    // ------------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------------
    assign irq_ev = {setup_refused, pulse_done, flag_fell, flag_rose};
    assign irq_clr = (wr && hit_is) ? pwdata[IRQ_W-1:0] : IRQ_RESET;

    // sticky status, set beats a same-cycle write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= IRQ_RESET;
            irq_mask <= IRQ_RESET;
            irq <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
            if (wr && hit_im) begin
                irq_mask <= pwdata[IRQ_W-1:0];
            end
            irq <= |(((irq_stat & ~irq_clr) | irq_ev) & irq_mask);
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    assign status_word = {20'h00000, seq, pin_s, pulse_active, sel_s, run_eff,
                          armed, bus_on_state, converters_off_flag};
    assign rd_mux = hit_cmd ? {8'h00, rb_byte(reg1, converters_off_flag),
                               rb_byte(reg0, converters_off_flag), 8'h00} :
                    hit_st ? status_word :
                    hit_is ? {28'h0000000, irq_stat} :
                    hit_im ? {28'h0000000, irq_mask} : 32'h00000000;

    // read data latched in the setup phase, held through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup_ph) begin
            prdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_pins_low;
        converters_off_flag |=> run_cpu_oe && run_io_oe && run_clk_oe && power_ok_oe;
    endproperty
    a_pins_low: assert property (p_pins_low) else $error("run pins not driven");

    property p_pins_float;
        !converters_off_flag |=> !run_cpu_oe && !run_io_oe && !run_clk_oe;
    endproperty
    a_pins_float: assert property (p_pins_float) else $error("run pins not released");

    property p_fall_pulse;
        $fell(converters_off_flag) |=> pulse_left == PG_PULSE_CYCLES ##0 power_ok_oe;
    endproperty
    a_fall_pulse: assert property (p_fall_pulse) else $error("no pulse on turn-on");

    property p_sel_pulse;
        sel_toggle && !converters_off_flag |=> pulse_left == PG_PULSE_CYCLES ##1 power_ok_oe;
    endproperty
    a_sel_pulse: assert property (p_sel_pulse) else $error("no pulse on select");

    property p_pulse_ends;
        $fell(pulse_active) && !converters_off_flag && !pulse_trig |=> !power_ok_oe;
    endproperty
    a_pulse_ends: assert property (p_pulse_ends) else $error("power-ok held too long");

    property p_code_sel;
        ##1 divider_code == ($past(sel_s) ? $past(reg1) : $past(reg0));
    endproperty
    a_code_sel: assert property (p_code_sel) else $error("wrong divider code");

    property p_reset_codes;
        !armed |-> reg0 == CODE_RESET && reg1 == CODE_RESET && converters_off_flag;
    endproperty
    a_reset_codes: assert property (p_reset_codes) else $error("state before setup");

    property p_lock;
        is_setup && locked |=> $stable(reg0) && $stable(reg1) && irq_stat[IRQ_REFUSE];
    endproperty
    a_lock: assert property (p_lock) else $error("locked codes changed");

    property p_on_pair;
        is_on && armed && seq == SEQ_ON1 |=> bus_on_state && seq == SEQ_IDLE;
    endproperty
    a_on_pair: assert property (p_on_pair) else $error("on pair not taken");

    property p_break;
        is_other |=> seq == SEQ_IDLE && $stable(bus_on_state);
    endproperty
    a_break: assert property (p_break) else $error("pair not broken");

    property p_flag;
        ##1 converters_off_flag == !((REDUCED_PINS || run_s) && $past(next_bus_on));
    endproperty
    a_flag: assert property (p_flag) else $error("shutdown flag wrong");

    c_turn_on: cover property ($fell(converters_off_flag));
    c_pulse_done: cover property (pulse_done && !converters_off_flag);
    c_refused: cover property (setup_refused);
    c_sel_run: cover property (sel_toggle && !converters_off_flag);

endmodule

// *** tb/cvrc_converter_model.sv ***
/*
 * behavioural far side of the run-control block: three converter run pins
 * with soft-start capacitors and a pulled-up power-ok line.
 * assumes the block drives each open-drain pin low while its _oe is high.
 */
module cvrc_converter_model #(
    parameter int SS_CYCLES = 8
) (
    // clock
    input wire logic pclk,
    // open-drain enables from the block
    input wire logic cpu_oe,
    input wire logic io_oe,
    input wire logic clk_oe,
    input wire logic pok_oe,
    // resolved pin levels
    output logic cpu_pin,
    output logic io_pin,
    output logic clk_pin,
    output logic pok_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] run_oe;
    int ss [3] = '{0, 0, 0};

    // an unknown enable counts as pulling low, so it never looks released
    assign run_oe = {clk_oe, io_oe, cpu_oe};

    // soft-start cap charges only while released, discharges at once
    always @(posedge pclk) begin
        for (int i = 0; i < 3; i++) begin
            if (run_oe[i] !== 1'b0) ss[i] <= 0;
            else if (ss[i] < SS_CYCLES) ss[i] <= ss[i] + 1;
        end
    end

    // pin level: low while pulled; run pins high once the cap has charged, power-ok at once
    assign cpu_pin = (cpu_oe === 1'b0) && (ss[0] >= SS_CYCLES);
    assign io_pin = (io_oe === 1'b0) && (ss[1] >= SS_CYCLES);
    assign clk_pin = (clk_oe === 1'b0) && (ss[2] >= SS_CYCLES);
    assign pok_pin = (pok_oe === 1'b0);
endmodule

// *** tb/cvrc_run_control_bench.sv ***
/*
 * self-checking bench for the run-control block: apb host tasks, one task
 * per scenario, converter model on the pins.
 * assumes zero-wait apb and a 20-cycle power-ok pulse for short runs.
 */
module cvrc_run_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import cvrc_pkg::*;
    localparam logic [TMR_W-1:0] PULSE = 16'h0014;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic pready, pslverr, err, global_run_input = 1'b0, select_in = 1'b0;
    logic cpu_pin, io_pin, clk_pin, pok_pin, cpu_oe, io_oe, clk_oe, pok_oe, irq, red_oe;
    logic [4:0] divider_code;
    logic [3:0] drv;
    int n_mismatch = 0, checked = 0, n;

    always #2 pclk = ~pclk;

    cvrc_run_control #(.PG_PULSE_CYCLES(PULSE), .REDUCED_PINS(1'b0)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .global_run_input(global_run_input), .select_in(select_in),
        .run_cpu_in(cpu_pin), .run_cpu_out(drv[0]), .run_cpu_oe(cpu_oe),
        .run_io_in(io_pin), .run_io_out(drv[1]), .run_io_oe(io_oe),
        .run_clk_in(clk_pin), .run_clk_out(drv[2]), .run_clk_oe(clk_oe),
        .power_ok_in(pok_pin), .power_ok_out(drv[3]), .power_ok_oe(pok_oe),
        .divider_code(divider_code), .irq(irq));

    // reduced-pin variant on the same bus: its run pin must be ignored
    cvrc_run_control #(.PG_PULSE_CYCLES(PULSE), .REDUCED_PINS(1'b1)) DUT_reduced (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
        .global_run_input(global_run_input), .select_in(select_in),
        .run_cpu_in(cpu_pin), .run_cpu_out(), .run_cpu_oe(red_oe),
        .run_io_in(io_pin), .run_io_out(), .run_io_oe(),
        .run_clk_in(clk_pin), .run_clk_out(), .run_clk_oe(),
        .power_ok_in(pok_pin), .power_ok_out(), .power_ok_oe(),
        .divider_code(), .irq());

    cvrc_converter_model #(.SS_CYCLES(8)) conv (.pclk(pclk), .cpu_oe(cpu_oe), .io_oe(io_oe),
        .clk_oe(clk_oe), .pok_oe(pok_oe), .cpu_pin(cpu_pin), .io_pin(io_pin),
        .clk_pin(clk_pin), .pok_pin(pok_pin));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) begin
            n_mismatch++;
            complete_run();
        end
    endtask

    task automatic cmd(input logic [2:0] code, input logic [4:0] lo, input logic [4:0] hi);
        apb(ADDR_CMD, 1'b1, (32'(lo) << (DLO_LSB + CODE_LSB)) | (32'(hi) << (DHI_LSB + CODE_LSB))
            | (32'(code) << CMD_LSB));
    endtask

    function automatic logic [31:0] rb(input logic [4:0] lo, input logic [4:0] hi, input logic f);
        return {8'h00, hi, f, 2'b00, lo, f, 2'b00, 8'h00};
    endfunction

    // bounded wait for the cpu run pin enable to reach a level
    task automatic wait_oe(input logic lvl);
        for (n = 0; n < 30 && cpu_oe !== lvl; n++) @(posedge pclk);
        if (n >= 30) begin
            n_mismatch++;
            complete_run();
        end
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        repeat (2) @(posedge pclk);
        check("pins after reset", {cpu_oe, io_oe, clk_oe, pok_oe}, 4'hF);
        check("code after reset", divider_code, 5'h1F);
        check("drive levels", drv, 4'h0);
        apb(ADDR_STATUS, 1'b0, 32'h0);
        check("flag and pair", {rd[ST_SEQ_LSB+1:ST_SEQ_LSB], rd[0]}, 3'h1);
        apb(ADDR_CMD, 1'b0, 32'h0);
        check("readback reset", rd, rb(5'h1F, 5'h1F, 1'b1));
        $display("test reset done");
    endtask

    task automatic t_on_early();
        global_run_input <= 1'b1;
        cmd(CMD_ON, 5'h00, 5'h00);
        cmd(CMD_ON, 5'h00, 5'h00);
        apb(ADDR_STATUS, 1'b0, 32'h0);
        check("on before setup", rd[1:0], 2'h1);
        global_run_input <= 1'b0;
        apb(8'h10, 1'b0, 32'h0);
        check("unmapped error", err, 1'b1);
        check("unmapped data", rd, 32'h0);
        $display("test early on done");
    endtask

    task automatic t_setup();
        cmd(CMD_SETUP, 5'h05, 5'h1A);
        apb(ADDR_CMD, 1'b0, 32'h0);
        check("readback", rd, rb(5'h05, 5'h1A, 1'b1));
        repeat (5) @(posedge pclk);
        check("sel low code", divider_code, 5'h05);
        select_in <= 1'b1;
        repeat (6) @(posedge pclk);
        check("sel high code", divider_code, 5'h1A);
        $display("test setup done");
    endtask

    task automatic t_pair();
        cmd(CMD_ON, 5'h00, 5'h00);
        apb(ADDR_CMD, 1'b0, 32'h0);
        cmd(CMD_ON, 5'h00, 5'h00);
        apb(ADDR_STATUS, 1'b0, 32'h0);
        check("broken pair", rd[1], 1'b0);
        cmd(CMD_ON, 5'h00, 5'h00);
        cmd(CMD_ON, 5'h00, 5'h00);
        apb(ADDR_STATUS, 1'b0, 32'h0);
        check("on pair, run low", rd[1:0], 2'h3);
        check("still pulled", {cpu_oe, io_oe, clk_oe, pok_oe}, 4'hF);
        check("reduced pins run", red_oe, 1'b0);
        $display("test pair done");
    endtask

    task automatic t_enable();
        apb(ADDR_IRQ_MASK, 1'b1, 32'h2);
        global_run_input <= 1'b1;
        wait_oe(1'b0);
        check("run pins float", {io_oe, clk_oe}, 2'h0);
        for (n = 0; n < 200 && pok_oe === 1'b1; n++) @(posedge pclk);
        check("pulse length", n >= PULSE - 1 && n <= PULSE + 2, 1'b1);
        apb(ADDR_STATUS, 1'b0, 32'h0);
        check("status on", {rd[9:6], rd[3], rd[1:0]}, 7'h7E);
        check("irq raised", irq, 1'b1);
        apb(ADDR_IRQ_STAT, 1'b1, 32'h2);
        repeat (2) @(posedge pclk);
        check("irq cleared", irq, 1'b0);
        $display("test enable done");
    endtask

    task automatic t_lock();
        cmd(CMD_SETUP, 5'h0A, 5'h0B);
        apb(ADDR_CMD, 1'b0, 32'h0);
        check("locked codes", rd, rb(5'h05, 5'h1A, 1'b0));
        apb(ADDR_IRQ_STAT, 1'b0, 32'h0);
        check("refuse event", rd[IRQ_REFUSE], 1'b1);
        $display("test lock done");
    endtask

    task automatic t_select();
        select_in <= 1'b0;
        for (n = 0; n < 10 && pok_oe !== 1'b1; n++) @(posedge pclk);
        check("toggle pulls pok", pok_oe, 1'b1);
        for (n = 0; n < 200 && pok_oe === 1'b1; n++) begin
            if (n == 8) select_in <= 1'b1;
            @(posedge pclk);
        end
        check("retrigger length", n > PULSE + 8 && n <= PULSE + 14, 1'b1);
        $display("test select done");
    endtask

    task automatic t_shutdown();
        global_run_input <= 1'b0;
        wait_oe(1'b1);
        @(posedge pclk);
        check("run low pulls all", {io_oe, clk_oe, pok_oe}, 3'h7);
        check("reduced ignores run", red_oe, 1'b0);
        apb(ADDR_STATUS, 1'b0, 32'h0);
        check("state kept", rd[1:0], 2'h3);
        global_run_input <= 1'b1;
        wait_oe(1'b0);
        cmd(CMD_OFF, 5'h00, 5'h00);
        cmd(CMD_OFF, 5'h00, 5'h00);
        wait_oe(1'b1);
        apb(ADDR_STATUS, 1'b0, 32'h0);
        check("off pair", rd[1:0], 2'h1);
        apb(ADDR_IRQ_STAT, 1'b0, 32'h0);
        check("all events seen", rd, 32'h0000000F);
        $display("test shutdown done");
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_on_early();
        t_setup();
        t_pair();
        t_enable();
        t_lock();
        t_select();
        t_shutdown();
        complete_run();
    end
endmodule
